/* File: core/plpg_top.sv */
`timescale 1ns/1ps
module plpg_top
  import plpg_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RESET,
  input  wire logic       REG_WR,
  input  wire logic       REG_ACC,
  input  wire logic [7:0] REG_ADDR,
  input  wire logic [7:0] REG_WDATA,
  output logic      [7:0] REG_RDATA,
  input  wire logic       PROX_START,
  input  wire logic       PROX_ENGINE_ON,
  input  wire logic       LIGHT_ENGINE_ON,
  input  wire logic       PROX_SAT_EVENT,
  input  wire logic       CLEAR_SAT_EVENT,
  input  wire logic       IRQ_NORMAL,
  output logic            PROX_BUSY,
  output logic            LED_SINK_PIN,
  output logic            INTEG_WINDOW,
  output logic            IRQ_PIN,
  output logic      [7:0] LED_CURRENT_LEVEL,
  output logic      [2:0] LED_CURRENT_BOOST,
  output logic      [3:0] PROX_GAIN_SEL,
  output logic      [6:0] LIGHT_GAIN_SEL,
  output logic            PROX_SAT_FLAG,
  output logic            CLEAR_SAT_FLAG,
  output logic            SAT_IRQ
);
  plpg_cfg_if cfg ();

  plpg_regs u_regs (
    .clk   (CLK),
    .reset (RESET),
    .wr_en (REG_WR),
    .addr  (REG_ADDR),
    .wdata (REG_WDATA),
    .cfg   (cfg)
  );

  // register readback; unmapped addresses read zero
  wire [7:0] rd_sel = (REG_ADDR == PULSE_SETUP_ADDR) ? cfg.pulse_setup :
                      (REG_ADDR == LED_GAIN_ADDR)    ? cfg.led_gain    :
                      (REG_ADDR == SAT_BOOST_ADDR)   ? cfg.sat_boost   :
                                                       8'h00;

  wire prox_en  = cfg.sat_boost[PSI_BIT];
  wire clear_en = cfg.sat_boost[CSI_BIT];
  wire route    = cfg.led_gain[ROUTE_BIT];
  wire invert   = cfg.led_gain[INV_BIT];

  // scaled gain codes as one-hot multipliers
  wire [1:0] pg = cfg.led_gain[PG_MSB:PG_LSB];
  wire [1:0] lg = cfg.led_gain[LG_MSB:0];
  wire [3:0] pg_sel = 4'(4'h1 << pg);
  wire [6:0] lg_sel = 7'(7'h01 << {lg, 1'b0});

  // current in eighths of full scale: 8, 4, 2, 1 -> 100..12.5 %
  wire [1:0] drv = cfg.led_gain[DRV_MSB:DRV_LSB];
  wire [3:0] base_eighths = 4'(4'h8 >> drv);
  // boost in halves: 2, 3, 4, 6 -> 100..300 %
  wire [1:0] bst = cfg.sat_boost[BST_MSB:BST_LSB];
  wire [2:0] boost_halves = (bst == 2'b11) ? 3'h6 : 3'({1'b0, bst} + 3'h2);
  // level = eighths * halves, units of 1/16 full scale; widen both
  // operands, since a 4-bit product would drop the top of 48
  wire [7:0] level_sel =
    {4'h0, base_eighths} * {5'h00, boost_halves};

  // data outputs leave through flops; readback lags the address by one
  // cycle, and no reset is needed as they reload on every edge
  logic [7:0] rd_r;
  logic [3:0] pg_r;
  logic [6:0] lg_r;
  logic [2:0] boost_r;
  logic [7:0] level_r;

  always_ff @(posedge CLK) begin
    rd_r    <= rd_sel;
    pg_r    <= pg_sel;
    lg_r    <= lg_sel;
    boost_r <= boost_halves;
    level_r <= level_sel;
  end

  assign REG_RDATA         = rd_r;
  assign PROX_GAIN_SEL     = pg_r;
  assign LIGHT_GAIN_SEL    = lg_r;
  assign LED_CURRENT_BOOST = boost_r;
  assign LED_CURRENT_LEVEL = level_r;

  // pulse engine
  plpg_state_e st_r, st_nxt;
  logic [5:0]       pcnt_r, pcnt_nxt;
  logic [CNT_W-1:0] tmr_r, tmr_nxt;
  logic [CNT_W-1:0] width_r, width_nxt;
  wire  [CNT_W-1:0] width_sel =
    CNT_W'(PW_BASE_CYC) << cfg.pulse_setup[PW_MSB:PW_LSB];
  wire              tmr_done = (tmr_r == CNT_W'(1));

  always_comb begin
    st_nxt    = st_r;
    pcnt_nxt  = pcnt_r;
    tmr_nxt   = (tmr_r != '0) ? CNT_W'(tmr_r - 1'b1) : tmr_r;
    width_nxt = width_r;
    unique case (st_r)
      ST_IDLE: begin
        if (PROX_START && PROX_ENGINE_ON) begin
          // settings taken once per train, at the start
          pcnt_nxt  = cfg.pulse_setup[PC_MSB:0];
          width_nxt = width_sel;
          tmr_nxt   = width_sel;
          st_nxt    = ST_ON;
        end
      end
      ST_ON: begin
        if (tmr_done) begin
          tmr_nxt = CNT_W'(LED_EXTRA_CYC);
          st_nxt  = ST_EXTRA;
        end
      end
      ST_EXTRA: begin
        if (tmr_done) begin
          if (pcnt_r == 6'h00) begin
            st_nxt = ST_IDLE;
          end else begin
            pcnt_nxt = 6'(pcnt_r - 1'b1);
            tmr_nxt  = width_r;
            st_nxt   = ST_OFF;
          end
        end
      end
      ST_OFF: begin
        // off gap equal to the width separates consecutive pulses
        if (tmr_done) begin
          tmr_nxt = width_r;
          st_nxt  = ST_ON;
        end
      end
    endcase
    if (!PROX_ENGINE_ON) begin
      st_nxt = ST_IDLE;
    end
  end

  always_ff @(posedge CLK) begin
    if (RESET) begin
      st_r    <= ST_IDLE;
      pcnt_r  <= 6'h00;
      tmr_r   <= '0;
      width_r <= '0;
    end else begin
      st_r    <= st_nxt;
      pcnt_r  <= pcnt_nxt;
      tmr_r   <= tmr_nxt;
      width_r <= width_nxt;
    end
  end

  logic led_r;
  logic integ_r;
  logic irq_r;
  wire  led_nxt = (st_nxt == ST_ON) || (st_nxt == ST_EXTRA);
  wire  integ_nxt = (st_nxt == ST_ON);
  wire  irq_nxt = route ? (led_nxt ^ invert)
                        : (IRQ_NORMAL | SAT_IRQ);

  always_ff @(posedge CLK) begin
    if (RESET) begin
      led_r   <= 1'b0;
      integ_r <= 1'b0;
      irq_r   <= 1'b0;
    end else begin
      led_r   <= led_nxt;
      integ_r <= integ_nxt;
      irq_r   <= irq_nxt;
    end
  end

  assign LED_SINK_PIN = led_r;
  assign INTEG_WINDOW = integ_r;
  assign IRQ_PIN      = irq_r;
  assign PROX_BUSY    = (st_r != ST_IDLE);

  // saturation flags; a set in the clearing cycle wins
  logic psat_r;
  logic csat_r;
  wire  prox_clr  = REG_ACC && ((REG_ADDR == PROX_CLR_ADDR)
                                || (REG_ADDR == ALL_CLR_ADDR));
  wire  clear_clr = REG_ACC && ((REG_ADDR == CLEAR_CLR_ADDR)
                                || (REG_ADDR == ALL_CLR_ADDR));

  always_ff @(posedge CLK) begin
    if (RESET) begin
      psat_r <= 1'b0;
      csat_r <= 1'b0;
    end else begin
      if (PROX_SAT_EVENT && PROX_ENGINE_ON) psat_r <= 1'b1;
      else if (prox_clr || !PROX_ENGINE_ON) psat_r <= 1'b0;
      if (CLEAR_SAT_EVENT && LIGHT_ENGINE_ON) csat_r <= 1'b1;
      else if (clear_clr || !LIGHT_ENGINE_ON) csat_r <= 1'b0;
    end
  end

  assign PROX_SAT_FLAG  = psat_r;
  assign CLEAR_SAT_FLAG = csat_r;
  assign SAT_IRQ = (psat_r && prox_en) || (csat_r && clear_en);

  property p_sat_prox_gate;
    @(posedge CLK) disable iff (RESET)
      (psat_r && !prox_en && !(csat_r && clear_en)) |-> !SAT_IRQ;
  endproperty
  a_sat_prox_gate: assert property (p_sat_prox_gate)
    else $error("prox saturation irq not gated");

  property p_sat_clear_gate;
    @(posedge CLK) disable iff (RESET)
      (csat_r && clear_en) |-> SAT_IRQ;
  endproperty
  a_sat_clear_gate: assert property (p_sat_clear_gate)
    else $error("clear saturation irq missing");

  property p_prox_clear;
    @(posedge CLK) disable iff (RESET)
      (prox_clr && !PROX_SAT_EVENT) |=> !psat_r;
  endproperty
  a_prox_clear: assert property (p_prox_clear)
    else $error("prox flag survived clear");

  property p_prox_sticky;
    @(posedge CLK) disable iff (RESET)
      (psat_r && !prox_clr && PROX_ENGINE_ON) |=> psat_r;
  endproperty
  a_prox_sticky: assert property (p_prox_sticky)
    else $error("prox flag dropped");

  property p_clear_off;
    @(posedge CLK) disable iff (RESET)
      (!LIGHT_ENGINE_ON && !CLEAR_SAT_EVENT) |=> !csat_r;
  endproperty
  a_clear_off: assert property (p_clear_off)
    else $error("clear flag held with light off");

  property p_extra_len;
    @(posedge CLK) disable iff (RESET)
      ($rose(st_r == ST_EXTRA) && PROX_ENGINE_ON)
        |-> (st_r == ST_EXTRA) [*8] ##1 (st_r == ST_EXTRA || !PROX_ENGINE_ON);
  endproperty
  a_extra_len: assert property (p_extra_len)
    else $error("extra led time too short");

  property p_route;
    @(posedge CLK) disable iff (RESET)
      (route && !invert && $stable(route)) |=> (IRQ_PIN == $past(led_nxt));
  endproperty
  a_route: assert property (p_route)
    else $error("routed irq differs from led");

  property p_invert;
    @(posedge CLK) disable iff (RESET)
      (route && invert) |=> (IRQ_PIN == !$past(led_nxt));
  endproperty
  a_invert: assert property (p_invert)
    else $error("routed irq not inverted");

  property p_start;
    @(posedge CLK) disable iff (RESET)
      (st_r == ST_IDLE && PROX_START && PROX_ENGINE_ON) |=> LED_SINK_PIN;
  endproperty
  a_start: assert property (p_start)
    else $error("led did not start");

  // run length and pulse tally, kept only for the checks below
  logic [CNT_W-1:0] led_run_r;
  logic             led_d_r;
  logic [6:0]       rise_cnt_r;
  logic [6:0]       want_cnt_r;

  always_ff @(posedge CLK) begin
    if (RESET) begin
      led_run_r  <= '0;
      led_d_r    <= 1'b0;
      rise_cnt_r <= 7'h00;
      want_cnt_r <= 7'h00;
    end else begin
      led_run_r <= LED_SINK_PIN ? CNT_W'(led_run_r + 1'b1) : '0;
      led_d_r   <= LED_SINK_PIN;
      if (st_r == ST_IDLE) begin
        rise_cnt_r <= 7'h00;
        want_cnt_r <= 7'({1'b0, cfg.pulse_setup[PC_MSB:0]} + 7'h01);
      end else if (LED_SINK_PIN && !led_d_r) begin
        rise_cnt_r <= 7'(rise_cnt_r + 1'b1);
      end
    end
  end

  property p_pulse_count;
    @(posedge CLK) disable iff (RESET)
      ($fell(PROX_BUSY) && $past(PROX_ENGINE_ON) && !$past(RESET))
        |-> (rise_cnt_r == want_cnt_r);
  endproperty
  a_pulse_count: assert property (p_pulse_count)
    else $error("pulse count differs from field plus one");

  property p_led_len;
    @(posedge CLK) disable iff (RESET)
      ($fell(LED_SINK_PIN) && $past(PROX_ENGINE_ON) && !$past(RESET))
        |-> (led_run_r == width_r + CNT_W'(LED_EXTRA_CYC));
  endproperty
  a_led_len: assert property (p_led_len)
    else $error("led on time differs from width plus extra");

  c_burst:  cover property (@(posedge CLK) $fell(PROX_BUSY));
  c_route:  cover property (@(posedge CLK) route && LED_SINK_PIN);
  c_psat:   cover property (@(posedge CLK) SAT_IRQ && psat_r);
  c_clrwin: cover property (@(posedge CLK) prox_clr && PROX_SAT_EVENT);
endmodule

/* File: core/plpg_pkg.sv */
package plpg_pkg;
  // register addresses
  localparam logic [7:0] PULSE_SETUP_ADDR = 8'h8E;
  localparam logic [7:0] LED_GAIN_ADDR    = 8'h8F;
  localparam logic [7:0] SAT_BOOST_ADDR   = 8'h90;
  localparam logic [7:0] PROX_CLR_ADDR    = 8'hE5;
  localparam logic [7:0] CLEAR_CLR_ADDR   = 8'hE6;
  localparam logic [7:0] ALL_CLR_ADDR     = 8'hE7;
  // reset values
  localparam logic [7:0] PULSE_SETUP_RST  = 8'h00;
  localparam logic [7:0] LED_GAIN_RST     = 8'h00;
  localparam logic [7:0] SAT_BOOST_RST    = 8'h01;
  // field positions
  localparam int PW_MSB = 7;
  localparam int PW_LSB = 6;
  localparam int PC_MSB = 5;
  localparam int DRV_MSB = 7;
  localparam int DRV_LSB = 6;
  localparam int ROUTE_BIT = 5;
  localparam int INV_BIT = 4;
  localparam int PG_MSB = 3;
  localparam int PG_LSB = 2;
  localparam int LG_MSB = 1;
  localparam int PSI_BIT = 7;
  localparam int CSI_BIT = 6;
  localparam int BST_MSB = 5;
  localparam int BST_LSB = 4;
  // timing
  localparam int CLK_MHZ = 100;
  localparam int PW_BASE_NS = 4000;
  localparam int PW_BASE_CYC = PW_BASE_NS * CLK_MHZ / 1000;
  localparam int LED_EXTRA_NS = 1360;
  localparam int LED_EXTRA_CYC = (LED_EXTRA_NS * CLK_MHZ + 999) / 1000;
  localparam int CNT_W = 13;
  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_ON    = 2'b01,
    ST_EXTRA = 2'b10,
    ST_OFF   = 2'b11
  } plpg_state_e;
endpackage

/* File: core/plpg_cfg_if.sv */
`timescale 1ns/1ps
interface plpg_cfg_if;
  logic [7:0] pulse_setup;
  logic [7:0] led_gain;
  logic [7:0] sat_boost;
  modport regs (output pulse_setup, output led_gain, output sat_boost);
  modport user (input pulse_setup, input led_gain, input sat_boost);
endinterface

/* File: core/plpg_regs.sv */
`timescale 1ns/1ps
module plpg_regs
  import plpg_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       reset,
  input  wire logic       wr_en,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] wdata,
  plpg_cfg_if.regs        cfg
);
  logic [7:0] pulse_r;
  logic [7:0] gain_r;
  logic [7:0] sat_r;
  wire        hit_pulse = wr_en && (addr == PULSE_SETUP_ADDR);
  wire        hit_gain  = wr_en && (addr == LED_GAIN_ADDR);
  wire        hit_sat   = wr_en && (addr == SAT_BOOST_ADDR);

  always_ff @(posedge clk) begin
    if (reset) begin
      pulse_r <= PULSE_SETUP_RST;
      gain_r  <= LED_GAIN_RST;
      sat_r   <= SAT_BOOST_RST;
    end else begin
      if (hit_pulse) pulse_r <= wdata;
      if (hit_gain)  gain_r  <= wdata;
      if (hit_sat)   sat_r   <= wdata;
    end
  end

  assign cfg.pulse_setup = pulse_r;
  assign cfg.led_gain    = gain_r;
  assign cfg.sat_boost   = sat_r;
endmodule

/* File: verif/tb.sv */
`timescale 1ns/1ps
module tb
  import plpg_pkg::*;
;
  logic       clk, rst, wr, acc, start, pon, lon, pev, cev, irqn;
  logic [7:0] addr, wdata, rdata, lvl;
  logic [2:0] bst;
  logic [3:0] pg;
  logic [6:0] lg;
  logic       busy, led, integ, irq, pflag, cflag, sirq;
  int         num_errors, tests_run, n_led, n_int, n_rise, cyc;
  int         seed;
  logic [7:0] d0, d1, d2;
  logic       prev;

  plpg_top dut (.CLK(clk), .RESET(rst), .REG_WR(wr), .REG_ACC(acc),
    .REG_ADDR(addr), .REG_WDATA(wdata), .REG_RDATA(rdata),
    .PROX_START(start), .PROX_ENGINE_ON(pon), .LIGHT_ENGINE_ON(lon),
    .PROX_SAT_EVENT(pev), .CLEAR_SAT_EVENT(cev), .IRQ_NORMAL(irqn),
    .PROX_BUSY(busy), .LED_SINK_PIN(led), .INTEG_WINDOW(integ),
    .IRQ_PIN(irq), .LED_CURRENT_LEVEL(lvl), .LED_CURRENT_BOOST(bst),
    .PROX_GAIN_SEL(pg), .LIGHT_GAIN_SEL(lg), .PROX_SAT_FLAG(pflag),
    .CLEAR_SAT_FLAG(cflag), .SAT_IRQ(sirq));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // boost expressed in halves: 2/3/4/6
  function automatic logic [2:0] exp_bst(logic [7:0] s);
    return (s[5:4] == 2'b11) ? 3'd6 : {1'b0, s[5:4]} + 3'd2;
  endfunction
  function automatic logic [7:0] exp_lvl(logic [7:0] c, logic [7:0] s);
    return (8'd8 >> c[7:6]) * {5'd0, exp_bst(s)};
  endfunction

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  // strobes stay up across back-to-back calls; idle() drops them
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    wr = 1'b1; acc = 1'b1; addr = a; wdata = d;
    step();
  endtask
  task automatic touch(input logic [7:0] a);
    wr = 1'b0; acc = 1'b1; addr = a;
    step();
  endtask
  task automatic idle();
    wr = 1'b0; acc = 1'b0;
    step();
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    addr = a;
    step();
    chk(rdata, e);
  endtask
  task automatic conclude();
    if (num_errors == 0 && tests_run > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // one train; a second start and a count rewrite land mid-train
  task automatic train(input logic [5:0] n, input logic [1:0] w,
                       input logic inv);
    wr_reg(PULSE_SETUP_ADDR, {w, n});
    wr_reg(LED_GAIN_ADDR, {2'b00, 1'b1, inv, 4'h0});
    idle();
    start = 1'b1;
    step();
    start = 1'b0;
    n_led = 0; n_int = 0; n_rise = 0; cyc = 0; prev = 1'b0;
    while (busy === 1'b1 && cyc < 40000) begin
      if (cyc == 10) begin
        start = 1'b1; wr = 1'b1; addr = PULSE_SETUP_ADDR; wdata = 8'hff;
      end
      if (cyc == 11) begin
        start = 1'b0; wr = 1'b0;
      end
      if (led === 1'b1) n_led++;
      if (integ === 1'b1) n_int++;
      if (led === 1'b1 && prev === 1'b0) n_rise++;
      if (led === prev && cyc > 2) chk(irq, led ^ inv);
      prev = led;
      cyc++;
      step();
    end
    chk(n_rise, n + 1);
    chk(n_int, (n + 1) * (PW_BASE_CYC << w));
    chk(n_led, (n + 1) * ((PW_BASE_CYC << w) + LED_EXTRA_CYC));
  endtask

  initial begin
    #900_000;
    num_errors++;
    conclude();
  end

  initial begin
    seed = 32'hb510_b80a;
    rst = 1'b1; wr = 1'b0; acc = 1'b0; start = 1'b0; pon = 1'b1;
    lon = 1'b1; pev = 1'b0; cev = 1'b0; irqn = 1'b0;
    addr = 8'h00; wdata = 8'h00;
    repeat (12) step();
    rst = 1'b0;
    rd_chk(PULSE_SETUP_ADDR, 8'h00);
    rd_chk(LED_GAIN_ADDR, 8'h00);
    rd_chk(SAT_BOOST_ADDR, 8'h01);
    rd_chk(8'h91, 8'h00);
    for (int i = 0; i < 24; i++) begin
      d0 = $random(seed);
      d1 = (i < 4) ? {i[1:0], 1'b0, d0[4], i[1:0], i[1:0]} : $random(seed);
      d2 = (i < 4) ? {2'b00, i[1:0], 4'h1} : {d0[7:4], 4'h1};
      d1[5] = 1'b0;
      irqn = d0[3];
      wr_reg(PULSE_SETUP_ADDR, d0);
      wr_reg(LED_GAIN_ADDR, d1);
      wr_reg(SAT_BOOST_ADDR, d2);
      wr_reg(8'h91, ~d0);
      idle();
      rd_chk(PULSE_SETUP_ADDR, d0);
      rd_chk(LED_GAIN_ADDR, d1);
      rd_chk(SAT_BOOST_ADDR, d2);
      rd_chk(8'h91, 8'h00);
      chk(pg, 4'd1 << d1[3:2]);
      chk(lg, 7'd1 << (2 * d1[1:0]));
      chk(bst, exp_bst(d2));
      chk(lvl, exp_lvl(d1, d2));
      chk(irq, irqn);
    end
    irqn = 1'b0;
    train(6'd0, 2'b11, 1'b0);
    train(6'd2, 2'b00, 1'b1);
    train(6'd1, 2'b01, 1'b0);
    wr_reg(LED_GAIN_ADDR, 8'h00);
    for (int e = 0; e < 4; e++) begin
      wr_reg(SAT_BOOST_ADDR, {e[1:0], 6'h01});
      idle();
      pev = 1'b1; cev = 1'b1;
      step();
      pev = 1'b0; cev = 1'b0;
      repeat (5) step();
      chk({pflag, cflag}, 2'b11);
      chk(sirq, e[1] | e[0]);
      chk(irq, e[1] | e[0]);
      touch(PROX_CLR_ADDR);
      idle();
      chk({pflag, cflag}, 2'b01);
      chk(sirq, e[0]);
      touch(CLEAR_CLR_ADDR);
      idle();
      chk({pflag, cflag}, 2'b00);
      pev = 1'b1; cev = 1'b1;
      touch(ALL_CLR_ADDR);
      pev = 1'b0; cev = 1'b0;
      chk({pflag, cflag}, 2'b11);
      touch(ALL_CLR_ADDR);
      idle();
      chk({pflag, cflag, sirq}, 3'b000);
    end
    pev = 1'b1; cev = 1'b1;
    step();
    pev = 1'b0; cev = 1'b0;
    pon = 1'b0;
    step();
    chk({pflag, cflag}, 2'b01);
    lon = 1'b0;
    step();
    chk({pflag, cflag}, 2'b00);
    conclude();
  end
endmodule
